// [hdl/srpg_defines.svh]
// constants for the system-reference pulse generator
// assumes a wishbone classic slave with 32-bit data, byte addressed
`ifndef SRPG_DEFINES_SVH
`define SRPG_DEFINES_SVH
`define SRPG_ADDR_DIV 4'h0
`define SRPG_ADDR_COUNT 4'h4
`define SRPG_ADDR_DELAY 4'h8
`define SRPG_ADDR_CTRL 4'hc
`define SRPG_ADDR_STAT 4'h0
`define SRPG_DIV_RST 7'h01
`define SRPG_COUNT_RST 8'h02
`define SRPG_DELAY_RST 8'h00
`define SRPG_CTRL_SRC 0
`define SRPG_CTRL_MODE 1
`define SRPG_CTRL_START 2
`define SRPG_CTRL_BIAS 3
`define SRPG_STEP_PS 509
`define SRPG_CLK_PS 5000
`endif

// [hdl/srpg_pkg.sv]
// types for the system-reference pulse generator
// assumes srpg_defines.svh is compiled first
package srpg_pkg;
   typedef enum logic [1:0] {
      SRPG_IDLE = 2'h0,
      SRPG_ALIGN = 2'h1,
      SRPG_RUN = 2'h3,
      SRPG_ARMED = 2'h2
   } srpg_state_e;
   typedef struct packed {
      logic [6:0] divSel;
      logic [7:0] pulseCount;
      logic [7:0] globalDelay;
      logic triggerSource;
      logic pulseMode;
      logic idleBias;
   } srpg_cfg_s;
endpackage : srpg_pkg

// [hdl/srpg_sysref_gen.sv]
// system-reference pulse generator: registers, release divider, burst engine
// assumes one clock, synchronous external trigger input, classic wishbone master
//
// Our own choices: register access over Wishbone and the register offsets.
`include "srpg_defines.svh"

module srpg_sysref_gen (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [3:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic externalTriggerPin,
   input wire logic forcedBiasControl,
   output logic sysrefPulse,
   output logic sysrefPowered,
   output logic alignStrobe,
   output logic [7:0] appliedDelay,
   output logic crossPointBias
);
   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   function automatic logic [4:0] divRatio(input logic [2:0] sel);
      unique case (sel)
         3'h0: divRatio = 5'h02;
         3'h1: divRatio = 5'h04;
         3'h2: divRatio = 5'h06;
         3'h3: divRatio = 5'h08;
         3'h4: divRatio = 5'h04;
         3'h5: divRatio = 5'h08;
         3'h6: divRatio = 5'h0c;
         3'h7: divRatio = 5'h10;
      endcase
   endfunction : divRatio

   function automatic logic [7:0] laneMerge(input logic [7:0] old, input logic [7:0] nw, input logic en);
      laneMerge = en ? nw : old;
   endfunction : laneMerge

   // delay steps per clock cycle, kept for the analog path model
   localparam int DELAY_STEPS_PER_CLK = `SRPG_CLK_PS / `SRPG_STEP_PS;

   // ---------------------------------------------------------------
   // register file
   // ---------------------------------------------------------------
   srpg_pkg::srpg_cfg_s cfg_ff, nxt_cfg_ff;
   logic ack_ff, nxt_ack_ff;
   logic [31:0] rdat_ff, nxt_rdat_ff;
   logic startWrite;
   logic startPending;
   logic busReq;
   logic busWrite;
   logic busRead;
   logic laneZero;

   // ack blocks a held strobe from being taken a second time
   assign busReq = wb_cyc_i && wb_stb_i && !ack_ff;
   assign busWrite = busReq && wb_we_i;
   assign busRead = busReq && !wb_we_i;
   assign laneZero = wb_sel_i[0];

   always_comb begin
      nxt_cfg_ff = cfg_ff;
      startWrite = 1'b0;
      if (busWrite) begin
         unique case (wb_adr_i)
            `SRPG_ADDR_DIV: nxt_cfg_ff.divSel = 7'(laneMerge({1'b0, cfg_ff.divSel}, wb_dat_i[7:0], laneZero));
            `SRPG_ADDR_COUNT: nxt_cfg_ff.pulseCount = laneMerge(cfg_ff.pulseCount, wb_dat_i[7:0], laneZero);
            `SRPG_ADDR_DELAY: nxt_cfg_ff.globalDelay = laneMerge(cfg_ff.globalDelay, wb_dat_i[7:0], laneZero);
            `SRPG_ADDR_CTRL: begin
               if (laneZero) begin
                  nxt_cfg_ff.triggerSource = wb_dat_i[`SRPG_CTRL_SRC];
                  nxt_cfg_ff.pulseMode = wb_dat_i[`SRPG_CTRL_MODE];
                  nxt_cfg_ff.idleBias = wb_dat_i[`SRPG_CTRL_BIAS];
                  // the strobe has no storage of its own: it acts once, in the taking cycle
                  startWrite = wb_dat_i[`SRPG_CTRL_START];
               end
            end
            default: ;
         endcase
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         cfg_ff <= '{
            divSel: `SRPG_DIV_RST,
            pulseCount: `SRPG_COUNT_RST,
            globalDelay: `SRPG_DELAY_RST,
            triggerSource: 1'b0,
            pulseMode: 1'b0,
            idleBias: 1'b0
         };
      end else begin
         cfg_ff <= nxt_cfg_ff;
      end
   end

   // ---------------------------------------------------------------
   // bus answer
   // ---------------------------------------------------------------
   always_comb begin
      nxt_ack_ff = busReq;
      nxt_rdat_ff = 32'h0;
      if (busRead) begin
         unique case (wb_adr_i)
            `SRPG_ADDR_DIV: nxt_rdat_ff = {25'h0, cfg_ff.divSel};
            `SRPG_ADDR_COUNT: nxt_rdat_ff = {24'h0, cfg_ff.pulseCount};
            `SRPG_ADDR_DELAY: nxt_rdat_ff = {24'h0, cfg_ff.globalDelay};
            // start bit reads as the live run status, since the strobe itself is write-only
            `SRPG_ADDR_CTRL: nxt_rdat_ff = {28'h0, cfg_ff.idleBias, startPending, cfg_ff.pulseMode,
                                            cfg_ff.triggerSource};
            // unmapped addresses still answer, with zero data
            default: nxt_rdat_ff = 32'h0;
         endcase
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         ack_ff <= 1'b0;
         rdat_ff <= 32'h0;
      end else begin
         ack_ff <= nxt_ack_ff;
         rdat_ff <= nxt_rdat_ff;
      end
   end

   assign wb_ack_o = ack_ff;
   assign wb_dat_o = rdat_ff;

   // ---------------------------------------------------------------
   // release divider and burst engine
   // ---------------------------------------------------------------
   srpg_pkg::srpg_state_e state_ff, nxt_state_ff;
   logic [4:0] divCnt_ff, nxt_divCnt_ff;
   logic [7:0] left_ff, nxt_left_ff;
   logic trigPrev_ff, nxt_trigPrev_ff;
   logic pulse_ff, nxt_pulse_ff;
   logic power_ff, nxt_power_ff;
   logic align_ff, nxt_align_ff;
   logic [7:0] delay_ff, nxt_delay_ff;

   logic releaseTick;
   logic trigRise;
   logic divRestart;
   logic countApplies;
   logic [4:0] ratio;

   assign ratio = divRatio(cfg_ff.divSel[5:3]);
   assign releaseTick = (divCnt_ff == 5'h00);
   // the pin is taken as synchronous; reset value equals its idle low, so reset never fakes an edge
   assign trigRise = externalTriggerPin && !trigPrev_ff;
   // in counted mode this drops on its own once the burst ends
   assign startPending = (state_ff != srpg_pkg::SRPG_IDLE);
   // a start or an accepted trigger restarts the divider on a common clock boundary
   assign divRestart = startWrite || ((state_ff == srpg_pkg::SRPG_ARMED) && trigRise);
   // count only honoured for internal, counted operation; uses the value being written
   assign countApplies = !nxt_cfg_ff.triggerSource && !nxt_cfg_ff.pulseMode;

   // ---------------------------------------------------------------
   // trigger edge detect
   // ---------------------------------------------------------------
   always_comb begin
      nxt_trigPrev_ff = externalTriggerPin;
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         trigPrev_ff <= 1'b0;
      end else begin
         trigPrev_ff <= nxt_trigPrev_ff;
      end
   end

   // ---------------------------------------------------------------
   // release divider
   // ---------------------------------------------------------------
   always_comb begin
      // counts down to zero; zero is the release boundary
      nxt_divCnt_ff = releaseTick ? 5'(ratio - 5'h01) : 5'(divCnt_ff - 5'h01);
      if (divRestart) begin
         nxt_divCnt_ff = 5'h00;
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         divCnt_ff <= 5'h00;
      end else begin
         divCnt_ff <= nxt_divCnt_ff;
      end
   end

   // ---------------------------------------------------------------
   // start capture: power, alignment, delay load
   // ---------------------------------------------------------------
   always_comb begin
      nxt_power_ff = power_ff;
      nxt_align_ff = 1'b0;
      nxt_delay_ff = delay_ff;
      if (startWrite) begin
         // power stays up until reset; nothing in this block turns it off again
         nxt_power_ff = 1'b1;
         nxt_align_ff = 1'b1;
         // delay moves only here, so a running burst never jumps phase
         nxt_delay_ff = cfg_ff.globalDelay;
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         power_ff <= 1'b0;
         align_ff <= 1'b0;
         delay_ff <= `SRPG_DELAY_RST;
      end else begin
         power_ff <= nxt_power_ff;
         align_ff <= nxt_align_ff;
         delay_ff <= nxt_delay_ff;
      end
   end

   // ---------------------------------------------------------------
   // burst sequencer
   // ---------------------------------------------------------------
   always_comb begin
      nxt_state_ff = state_ff;
      nxt_left_ff = left_ff;
      nxt_pulse_ff = 1'b0;
      // a start always wins, so a write during a burst restarts it cleanly
      if (startWrite) begin
         nxt_left_ff = countApplies ? nxt_cfg_ff.pulseCount : 8'h01;
         nxt_state_ff = nxt_cfg_ff.triggerSource ? srpg_pkg::SRPG_ARMED
                                                 : srpg_pkg::SRPG_RUN;
      end else begin
         unique case (state_ff)
            srpg_pkg::SRPG_IDLE: ;
            srpg_pkg::SRPG_ARMED: begin
               if (trigRise) begin
                  nxt_state_ff = srpg_pkg::SRPG_RUN;
               end
            end
            // not entered by start; steps straight on so a stray code cannot hang the engine
            srpg_pkg::SRPG_ALIGN: nxt_state_ff = srpg_pkg::SRPG_RUN;
            srpg_pkg::SRPG_RUN: begin
               if (releaseTick) begin
                  if (cfg_ff.pulseMode) begin
                     nxt_pulse_ff = 1'b1;
                  end else if (left_ff != 8'h00) begin
                     nxt_pulse_ff = 1'b1;
                     nxt_left_ff = 8'(left_ff - 8'h01);
                     if (left_ff == 8'h01) begin
                        nxt_state_ff = srpg_pkg::SRPG_IDLE;
                     end
                  end else begin
                     // a zero count releases nothing and gives up at the next boundary
                     nxt_state_ff = srpg_pkg::SRPG_IDLE;
                  end
               end
            end
         endcase
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         state_ff <= srpg_pkg::SRPG_IDLE;
         left_ff <= 8'h00;
         pulse_ff <= 1'b0;
      end else begin
         state_ff <= nxt_state_ff;
         left_ff <= nxt_left_ff;
         pulse_ff <= nxt_pulse_ff;
      end
   end

   // ---------------------------------------------------------------
   // outputs
   // ---------------------------------------------------------------
   // forced bias blanks pulses; bias style chosen by idle bias select
   assign sysrefPulse = pulse_ff && !forcedBiasControl;
   assign crossPointBias = cfg_ff.idleBias && (forcedBiasControl || !pulse_ff);
   assign sysrefPowered = power_ff;
   assign alignStrobe = align_ff;
   assign appliedDelay = delay_ff;
endmodule : srpg_sysref_gen

// [tb/srpg_props.sv]
// port checker for the system-reference pulse generator
// assumes it is bound onto every srpg_sysref_gen instance
// ---
// assertions
// ---
module srpg_props (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [3:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o,
   input wire logic externalTriggerPin,
   input wire logic forcedBiasControl,
   input wire logic sysrefPulse,
   input wire logic sysrefPowered,
   input wire logic alignStrobe,
   input wire logic [7:0] appliedDelay,
   input wire logic crossPointBias
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_n);
   sequence taken;
      wb_cyc_i && wb_stb_i && !wb_ack_o;
   endsequence
   sequence startWr;
      taken ##0 (wb_we_i && wb_adr_i == 4'hc && wb_sel_i[0] && wb_dat_i[2]);
   endsequence
   ack_answer_a: assert property (taken |=> wb_ack_o) else $error("bus request not acknowledged");
   ack_single_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held two cycles");
   start_align_a: assert property (startWr |=> alignStrobe && sysrefPowered) else $error("start not taken");
   power_hold_a: assert property (sysrefPowered |=> sysrefPowered) else $error("power dropped");
   pulse_power_a: assert property (sysrefPulse |-> sysrefPowered) else $error("pulse while off");
   delay_load_a: assert property (!$stable(appliedDelay) |-> alignStrobe) else $error("delay moved");
   pulse_gap_a: assert property (sysrefPulse && !alignStrobe |=> !sysrefPulse) else $error("pulses adjacent");
   bias_pulse_a: assert property (sysrefPulse && !forcedBiasControl |-> !crossPointBias) else $error("bias in pulse");
endmodule : srpg_props

bind srpg_sysref_gen srpg_props chk (.clock(clock), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
   .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
   .wb_ack_o(wb_ack_o), .externalTriggerPin(externalTriggerPin), .forcedBiasControl(forcedBiasControl),
   .sysrefPulse(sysrefPulse), .sysrefPowered(sysrefPowered), .alignStrobe(alignStrobe),
   .appliedDelay(appliedDelay), .crossPointBias(crossPointBias));

// [tb/srpg_trig_src.sv]
// outside trigger source driving the external trigger pin
// assumes fire is a one-cycle request from the bench
// ---
// edge generator
// ---
module srpg_trig_src #(parameter int HOLD = 4) (
   input wire logic clock,
   input wire logic fire,
   output logic pin
);
   timeunit 1ns;
   timeprecision 1ps;
   int left = 0;
   always @(posedge clock) begin
      left <= fire ? HOLD : (left > 0 ? left - 1 : 0);
      pin <= fire || left > 1;
   end
endmodule : srpg_trig_src

// [tb/tb.sv]
// self-checking bench for the pulse generator
// assumes nothing on ack latency; each access waits for the ack
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic clock = 1'b0;
   logic rst_n = 1'b0;
   logic req = 1'b0;
   logic we = 1'b0;
   logic fire = 1'b0;
   logic forced = 1'b0;
   logic [3:0] adr = 4'h0;
   logic [3:0] sel = 4'h0;
   logic [3:0] useSel = 4'hf;
   logic [31:0] dat = 32'h0;
   logic [31:0] rd, datO;
   logic ack, pulse, powered, align, cpb, pin;
   logic [7:0] dly;
   int fail_count = 0;
   int check_count = 0;
   int pulses = 0;
   int gap = 0;
   int lastAt = 0;
   int cycN = 0;
   int p0;
   always #2.5 clock = ~clock;
   // ---
   // pulse monitor
   // ---
   always @(posedge clock) begin
      cycN <= cycN + 1;
      if (pulse === 1'b1) begin
         pulses <= pulses + 1;
         gap <= cycN - lastAt;
         lastAt <= cycN;
      end
   end
   srpg_sysref_gen uut (.clock(clock), .rst_n(rst_n), .wb_cyc_i(req), .wb_stb_i(req), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(datO), .wb_ack_o(ack),
      .externalTriggerPin(pin), .forcedBiasControl(forced), .sysrefPulse(pulse), .sysrefPowered(powered),
      .alignStrobe(align), .appliedDelay(dly), .crossPointBias(cpb));
   srpg_trig_src src (.clock(clock), .fire(fire), .pin(pin));
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      check_count++;
      if (got !== exp) begin
         $display("ERROR %s expected %h seen %h", what, exp, got);
         fail_count++;
      end
   endtask : chk
   task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
      @(posedge clock);
      req <= 1'b1;
      we <= w;
      adr <= a;
      sel <= useSel;
      dat <= d;
      // no answer time assumed; only the watchdog ends a lost answer
      do begin
         @(posedge clock);
      end while (ack !== 1'b1);
      rd = datO;
      req <= 1'b0;
      we <= 1'b0;
      sel <= 4'h0;
   endtask : bus
   task automatic wait_count(input int cycles, input string what, input int exp);
      repeat (cycles) @(posedge clock);
      chk(what, exp, pulses - p0);
   endtask : wait_count
   task automatic t_regs;
      bus(0, 4'h0, 0); chk("divider", 32'h01, rd);
      bus(0, 4'h4, 0); chk("count", 32'h02, rd);
      bus(0, 4'h8, 0); chk("delay", 32'h00, rd);
      bus(0, 4'h2, 0); chk("unmapped", 32'h00, rd);
      useSel = 4'he;
      bus(1, 4'h4, 32'h7);
      useSel = 4'hf;
      bus(0, 4'h4, 0);
      chk("masked write", 32'h02, rd);
      bus(1, 4'h8, 32'hff);
      @(posedge clock);
      chk("delay before start", 32'h00, {24'h0, dly});
      p0 = pulses;
      bus(1, 4'hc, 32'h4);
      @(posedge clock);
      chk("delay after start", 32'hff, {24'h0, dly});
      chk("powered", 1, {31'h0, powered});
      wait_count(20, "default burst", 2);
      $display("t_regs done");
   endtask : t_regs
   task automatic t_ratio;
      int r[8] = '{2, 4, 6, 8, 4, 8, 12, 16};
      bus(1, 4'h4, 32'h3);
      for (int k = 0; k < 8; k++) begin
         bus(1, 4'h0, {26'h0, k[2:0], 3'h0});
         p0 = pulses;
         bus(1, 4'hc, 32'h4);
         wait_count(60, "burst size", 3);
         chk("pulse gap", r[k], gap);
      end
      bus(0, 4'hc, 0); chk("start cleared", 32'h0, rd);
      $display("t_ratio done");
   endtask : t_ratio
   task automatic t_cont;
      bus(1, 4'h0, 32'h0);
      p0 = pulses;
      bus(1, 4'hc, 32'h6);
      repeat (40) @(posedge clock);
      chk("continuous", 1, {31'h0, (pulses - p0) > 10});
      bus(0, 4'hc, 0); chk("start held", 1, {31'h0, rd[2]});
      bus(1, 4'hc, 32'h4);
      repeat (20) @(posedge clock);
      $display("t_cont done");
   endtask : t_cont
   task automatic t_ext;
      p0 = pulses;
      bus(1, 4'hc, 32'h5);
      wait_count(20, "armed idle", 0);
      fire <= 1'b1;
      @(posedge clock);
      fire <= 1'b0;
      wait_count(20, "triggered", 1);
      $display("t_ext done");
   endtask : t_ext
   task automatic t_bias;
      forced <= 1'b1;
      p0 = pulses;
      bus(1, 4'hc, 32'hc);
      wait_count(30, "forced blank", 0);
      chk("cross bias", 1, {31'h0, cpb});
      forced <= 1'b0;
      $display("t_bias done");
   endtask : t_bias
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : wrap_up
   initial begin
      repeat (12) @(posedge clock);
      rst_n <= 1'b1;
      t_regs;
      t_ratio;
      t_cont;
      t_ext;
      t_bias;
      wrap_up;
   end
   initial begin
      repeat (5000) @(posedge clock);
      fail_count++;
      wrap_up;
   end
endmodule : tb
